/* misc_config_register_bank.sv */
module misc_config_register_bank #(
  // Arbitrary value; it only tells this build apart from others.
  parameter logic [7:0] PART_CODE = 8'hA5
) (
  input  wire logic                      i_core_clk,
  input  wire logic                      i_reset_n,
  input  wire logic                      i_clk_en,
  input  wire misc_cfg_pkg::reg_access_t i_access,
  output logic [7:0]                     o_rdata,
  input  wire logic                      i_hang_detect,
  input  wire logic                      i_src_clk_en,
  input  wire logic [6:0]                i_bus_addr,
  input  wire logic [6:0]                i_own_addr,
  output logic                           o_addr_match,
  output logic                           o_div_pulse,
  output misc_cfg_pkg::misc_ctrl_t       o_ctrl
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [7:0] page_q,  page_d;
  logic [7:0] ramp_q,  ramp_d;
  logic [7:0] prot_q,  prot_d;
  logic [7:0] mux_q,   mux_d;
  logic [7:0] div_q,   div_d;
  logic [7:0] opts_q,  opts_d;
  logic       hang_seen_q, hang_seen_d;
  logic [7:0] rdata_q, rdata_d;
  logic       on_misc, on_ramp;
  logic       rd_hang;

  // ****************************************************************
  // Decoding
  // ****************************************************************
  // A register is hit only while the page that holds it is selected.
  function automatic logic reg_hit(input logic       page_ok,
                                   input logic [7:0] addr,
                                   input logic [7:0] want_addr);
    return page_ok && (addr == want_addr);
  endfunction

  logic hit_mux, hit_div, hit_opts, hit_id, hit_ramp, hit_prot, hit_stray;

  assign on_misc   = (page_q == misc_cfg_pkg::MISC_PAGE);
  assign on_ramp   = (page_q == misc_cfg_pkg::RAMP_PAGE);
  assign hit_mux   = reg_hit(on_misc, i_access.addr, misc_cfg_pkg::CLKOUT_MUX_ADDR);
  assign hit_div   = reg_hit(on_misc, i_access.addr, misc_cfg_pkg::CLKOUT_DIV_ADDR);
  assign hit_opts  = reg_hit(on_misc, i_access.addr, misc_cfg_pkg::BUS_OPTIONS_ADDR);
  assign hit_id    = reg_hit(on_misc, i_access.addr, misc_cfg_pkg::PART_ID_ADDR);
  assign hit_ramp  = reg_hit(on_ramp, i_access.addr, misc_cfg_pkg::RAMP_CTRL_ADDR);
  assign hit_prot  = reg_hit(on_ramp, i_access.addr, misc_cfg_pkg::PROTECTION_ADDR);
  assign hit_stray = !on_misc && !on_ramp
                   && (i_access.addr != misc_cfg_pkg::PAGE_SELECT_ADDR);
  assign rd_hang   = i_access.read && hit_opts;

  always_comb begin
    page_d      = page_q;
    ramp_d      = ramp_q;
    prot_d      = prot_q;
    mux_d       = mux_q;
    div_d       = div_q;
    opts_d      = opts_q;
    hang_seen_d = hang_seen_q;
    rdata_d     = rdata_q;
    if (rd_hang) begin
      hang_seen_d = 1'b0;
    end
    if (i_access.write) begin
      if (i_access.addr == misc_cfg_pkg::PAGE_SELECT_ADDR) begin
        page_d = i_access.wdata;
      end else if (on_misc) begin
        unique case (i_access.addr)
          misc_cfg_pkg::CLKOUT_MUX_ADDR: mux_d = i_access.wdata & misc_cfg_pkg::CLKOUT_MUX_MASK;
          misc_cfg_pkg::CLKOUT_DIV_ADDR: div_d = i_access.wdata;
          misc_cfg_pkg::BUS_OPTIONS_ADDR: begin
            // The hang bit is read-only status; a written value is dropped.
            opts_d = i_access.wdata;
            opts_d[misc_cfg_pkg::BUS_HANG_BIT] = 1'b0;
          end
          default: ;
        endcase
      end else if (on_ramp) begin
        unique case (i_access.addr)
          misc_cfg_pkg::RAMP_CTRL_ADDR:  ramp_d = i_access.wdata;
          misc_cfg_pkg::PROTECTION_ADDR: prot_d = i_access.wdata;
          default: ;
        endcase
      end
    end
    // A hang arriving in the read cycle wins over the clear.
    if (i_hang_detect) begin
      hang_seen_d = 1'b1;
    end
    if (i_access.read) begin
      rdata_d = 8'h00;
      if (i_access.addr == misc_cfg_pkg::PAGE_SELECT_ADDR) begin
        rdata_d = page_q;
      end else if (on_misc) begin
        unique case (i_access.addr)
          misc_cfg_pkg::CLKOUT_MUX_ADDR: rdata_d = mux_q;
          misc_cfg_pkg::CLKOUT_DIV_ADDR: rdata_d = div_q;
          misc_cfg_pkg::BUS_OPTIONS_ADDR: begin
            rdata_d = opts_q;
            rdata_d[misc_cfg_pkg::BUS_HANG_BIT] = ~hang_seen_q;
          end
          misc_cfg_pkg::PART_ID_ADDR: rdata_d = PART_CODE;
          default: rdata_d = 8'h00;
        endcase
      end else if (on_ramp) begin
        unique case (i_access.addr)
          misc_cfg_pkg::RAMP_CTRL_ADDR:  rdata_d = ramp_q;
          misc_cfg_pkg::PROTECTION_ADDR: rdata_d = prot_q;
          default: rdata_d = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      page_q      <= misc_cfg_pkg::PAGE_SELECT_RST;
      ramp_q      <= misc_cfg_pkg::RAMP_CTRL_RST;
      prot_q      <= misc_cfg_pkg::PROTECTION_RST;
      mux_q       <= misc_cfg_pkg::CLKOUT_MUX_RST;
      div_q       <= misc_cfg_pkg::CLKOUT_DIV_RST;
      opts_q      <= misc_cfg_pkg::BUS_OPTIONS_RST;
      // The flag starts out as seen, so the options byte reads its reset value.
      hang_seen_q <= ~misc_cfg_pkg::BUS_OPTIONS_RST[misc_cfg_pkg::BUS_HANG_BIT];
      rdata_q     <= 8'h00;
    end else if (i_clk_en) begin
      page_q      <= page_d;
      ramp_q      <= ramp_d;
      prot_q      <= prot_d;
      mux_q       <= mux_d;
      div_q       <= div_d;
      opts_q      <= opts_d;
      hang_seen_q <= hang_seen_d;
      rdata_q     <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_comb begin
    o_ctrl.divider_power_on       = div_q[misc_cfg_pkg::DIVIDER_POWER_BIT];
    o_ctrl.divider_clock_input    = mux_q[4:0];
    o_ctrl.ramp_freq              = misc_cfg_pkg::ramp_freq_t'(
                                      ramp_q[misc_cfg_pkg::RAMP_FREQ_LSB +: 2]);
    o_ctrl.ramp_spread_depth      = misc_cfg_pkg::spread_depth_t'(
                                      ramp_q[misc_cfg_pkg::RAMP_SPREAD_LSB +: 2]);
    o_ctrl.overtemp_retry_disable = prot_q[misc_cfg_pkg::OVERTEMP_RETRY_BIT];
    o_ctrl.general_call_enable    = opts_q[misc_cfg_pkg::GENERAL_CALL_BIT];
  end

  // Address matching for the serial port front end.
  assign o_addr_match = (i_bus_addr == i_own_addr)
                      || (opts_q[misc_cfg_pkg::GENERAL_CALL_BIT]
                          && (i_bus_addr == misc_cfg_pkg::GENERAL_CALL_ADDR));

  clkout_divider u_div (
    .i_core_clk   (i_core_clk),
    .i_reset_n    (i_reset_n),
    .i_clk_en     (i_clk_en),
    .i_src_clk_en (i_src_clk_en),
    .i_power_on   (div_q[misc_cfg_pkg::DIVIDER_POWER_BIT]),
    .i_ratio      (div_q[6:0]),
    .o_div_pulse  (o_div_pulse)
  );

  // ****************************************************************
  // Divider checks
  // ****************************************************************
  div_off_quiet_a : assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_clk_en && !div_q[misc_cfg_pkg::DIVIDER_POWER_BIT]) |=> !o_div_pulse)
    else $error("divider pulsed while off");

  div_power_a : assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_clk_en && i_access.write && hit_div)
    |=> o_ctrl.divider_power_on == $past(i_access.wdata[misc_cfg_pkg::DIVIDER_POWER_BIT]))
    else $error("divider power bit not applied");

  div_by_one_a : assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_clk_en && i_src_clk_en && o_ctrl.divider_power_on && div_q[6:0] == 7'h01)
    |=> o_div_pulse)
    else $error("divide by one missed a tick");

  div_source_a : assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_clk_en && i_access.write && hit_mux)
    |=> o_ctrl.divider_clock_input == $past(i_access.wdata[4:0]))
    else $error("divider source not applied");

  // ****************************************************************
  // Serial port checks
  // ****************************************************************
  hang_set_a : assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_clk_en && i_hang_detect) |=> hang_seen_q)
    else $error("hang not caught");

  hang_clear_a : assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_clk_en && rd_hang && !i_hang_detect) |=> !hang_seen_q)
    else $error("hang not cleared by read");

  hang_report_a : assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_clk_en && rd_hang)
    |=> o_rdata[misc_cfg_pkg::BUS_HANG_BIT] == !$past(hang_seen_q))
    else $error("hang flag read with wrong sense");

  hang_keep_a : assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_clk_en && i_access.write && !i_access.read && hit_opts && !i_hang_detect)
    |=> hang_seen_q == $past(hang_seen_q))
    else $error("hang flag changed by a write");

  gcall_off_a : assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_bus_addr == misc_cfg_pkg::GENERAL_CALL_ADDR && i_bus_addr != i_own_addr
     && !o_ctrl.general_call_enable) |-> !o_addr_match)
    else $error("general call answered while disabled");

  gcall_on_a : assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_bus_addr == misc_cfg_pkg::GENERAL_CALL_ADDR && o_ctrl.general_call_enable)
    |-> o_addr_match)
    else $error("general call ignored while enabled");

  own_match_a : assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_bus_addr == i_own_addr) |-> o_addr_match)
    else $error("own address ignored");

  // ****************************************************************
  // Identification and page checks
  // ****************************************************************
  id_read_a : assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_clk_en && i_access.read && hit_id) |=> o_rdata == PART_CODE)
    else $error("identification wrong");

  id_write_a : assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_clk_en && i_access.write && hit_id)
    |=> {page_q, ramp_q, prot_q, mux_q, div_q, opts_q}
        == $past({page_q, ramp_q, prot_q, mux_q, div_q, opts_q}))
    else $error("identification write changed a register");

  page_write_a : assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_clk_en && i_access.write && i_access.addr == misc_cfg_pkg::PAGE_SELECT_ADDR)
    |=> page_q == $past(i_access.wdata))
    else $error("page not written");

  page_stray_write_a : assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_clk_en && i_access.write && hit_stray)
    |=> {ramp_q, prot_q, mux_q, div_q, opts_q}
        == $past({ramp_q, prot_q, mux_q, div_q, opts_q}))
    else $error("write on unknown page changed a register");

  page_stray_read_a : assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_clk_en && i_access.read && hit_stray) |=> o_rdata == 8'h00)
    else $error("read on unknown page returned data");

  // ****************************************************************
  // Ramp and protection checks
  // ****************************************************************
  ramp_out_a : assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_clk_en && i_access.write && hit_ramp)
    |=> o_ctrl.ramp_freq == $past(i_access.wdata[misc_cfg_pkg::RAMP_FREQ_LSB +: 2]))
    else $error("ramp code not applied");

  spread_out_a : assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_clk_en && i_access.write && hit_ramp)
    |=> o_ctrl.ramp_spread_depth == $past(i_access.wdata[misc_cfg_pkg::RAMP_SPREAD_LSB +: 2]))
    else $error("spread code not applied");

  retry_out_a : assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (i_clk_en && i_access.write && hit_prot)
    |=> o_ctrl.overtemp_retry_disable
        == $past(i_access.wdata[misc_cfg_pkg::OVERTEMP_RETRY_BIT]))
    else $error("retry bit not applied");

  // ****************************************************************
  // Clock enable checks
  // ****************************************************************
  clk_freeze_a : assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    !i_clk_en
    |=> {page_q, ramp_q, prot_q, mux_q, div_q, opts_q, hang_seen_q, rdata_q}
        == $past({page_q, ramp_q, prot_q, mux_q, div_q, opts_q, hang_seen_q, rdata_q}))
    else $error("state moved while clock enable low");

endmodule

/* misc_cfg_pkg.sv */
package misc_cfg_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] PAGE_SELECT_ADDR       = 8'h00;
  localparam logic [7:0] RAMP_CTRL_ADDR         = 8'h06;
  localparam logic [7:0] PROTECTION_ADDR        = 8'h09;
  localparam logic [7:0] CLKOUT_MUX_ADDR        = 8'h75;
  localparam logic [7:0] CLKOUT_DIV_ADDR        = 8'h76;
  localparam logic [7:0] BUS_OPTIONS_ADDR       = 8'h7C;
  localparam logic [7:0] PART_ID_ADDR           = 8'h7D;

  localparam logic [7:0] MISC_PAGE              = 8'h01;
  localparam logic [7:0] RAMP_PAGE              = 8'h02;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] PAGE_SELECT_RST        = 8'h01;
  localparam logic [7:0] RAMP_CTRL_RST          = 8'h00;
  localparam logic [7:0] PROTECTION_RST         = 8'h03;
  localparam logic [7:0] CLKOUT_MUX_RST         = 8'h0D;
  localparam logic [7:0] CLKOUT_DIV_RST         = 8'h01;
  localparam logic [7:0] BUS_OPTIONS_RST        = 8'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int DIVIDER_POWER_BIT              = 7;
  localparam int BUS_HANG_BIT                   = 6;
  localparam int GENERAL_CALL_BIT               = 5;
  localparam int OVERTEMP_RETRY_BIT             = 2;
  localparam int RAMP_FREQ_LSB                  = 4;
  localparam int RAMP_SPREAD_LSB                = 0;
  localparam logic [7:0] CLKOUT_MUX_MASK        = 8'h1F;

  localparam logic [6:0] GENERAL_CALL_ADDR      = 7'h00;

  typedef enum logic [1:0] {
    RAMP_384K   = 2'b00,
    RAMP_352K8  = 2'b01,
    RAMP_RSVD   = 2'b10,
    RAMP_RSVD3  = 2'b11
  } ramp_freq_t;

  typedef enum logic [1:0] {
    SPREAD_RSVD0 = 2'b00,
    SPREAD_5PCT  = 2'b01,
    SPREAD_10PCT = 2'b10,
    SPREAD_RSVD3 = 2'b11
  } spread_depth_t;

  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_access_t;

  typedef struct packed {
    logic          divider_power_on;
    logic [4:0]    divider_clock_input;
    ramp_freq_t    ramp_freq;
    spread_depth_t ramp_spread_depth;
    logic          overtemp_retry_disable;
    logic          general_call_enable;
  } misc_ctrl_t;

endpackage

/* clkout_divider.sv */
module clkout_divider (
  input  wire logic       i_core_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_clk_en,
  input  wire logic       i_src_clk_en,
  input  wire logic       i_power_on,
  input  wire logic [6:0] i_ratio,
  output logic            o_div_pulse
);

  logic [7:0] count_q;
  logic [7:0] count_d;
  logic       pulse_q;
  logic       pulse_d;
  logic [7:0] terminal;

  // A ratio code of zero means divide by 128.
  assign terminal = (i_ratio == 7'h00) ? 8'h80 : {1'b0, i_ratio};

  always_comb begin
    count_d = count_q;
    pulse_d = 1'b0;
    if (!i_power_on) begin
      count_d = 8'h00;
    end else if (i_src_clk_en) begin
      if (count_q + 8'h01 >= terminal) begin
        count_d = 8'h00;
        pulse_d = 1'b1;
      end else begin
        count_d = count_q + 8'h01;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count_q <= 8'h00;
      pulse_q <= 1'b0;
    end else if (i_clk_en) begin
      count_q <= count_d;
      pulse_q <= pulse_d;
    end
  end

  assign o_div_pulse = pulse_q;

endmodule

/* host_bus_model.sv */
module host_bus_model (
  input  wire logic                  i_core_clk,
  input  wire logic [7:0]            i_rdata,
  output misc_cfg_pkg::reg_access_t  o_access
);
  timeunit 1ns;
  timeprecision 1ps;

  initial o_access = '0;

  // Idle address lines show the inverse of the last request; data lines flip on each release, so after one read following a write they show the written data.
  task automatic release_bus();
    o_access = '{1'b0, 1'b0, ~o_access.addr, ~o_access.wdata};
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge i_core_clk);
    o_access.write = 1'b1;
    o_access.addr  = addr;
    o_access.wdata = (addr == misc_cfg_pkg::BUS_OPTIONS_ADDR) ? (data & 8'hBF) : data;
    @(negedge i_core_clk);
    release_bus();
  endtask

  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(negedge i_core_clk);
    o_access.read = 1'b1;
    o_access.addr = addr;
    @(negedge i_core_clk);
    release_bus();
    data = i_rdata;
  endtask

  task automatic rmw(input logic [7:0] addr, input logic [7:0] mask, input logic [7:0] val);
    logic [7:0] cur;
    rd(addr, cur);
    wr(addr, (cur & ~mask) | (val & mask));
  endtask
endmodule

/* misc_config_register_bank_tb_top.sv */
module misc_config_register_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // Arbitrary identification value for the bench build.
  localparam logic [7:0] PART_CODE_TB = 8'h5C;
  localparam logic [7:0] OPT          = misc_cfg_pkg::BUS_OPTIONS_ADDR;
  localparam logic [7:0] DIV          = misc_cfg_pkg::CLKOUT_DIV_ADDR;
  localparam logic [7:0] MUX          = misc_cfg_pkg::CLKOUT_MUX_ADDR;
  localparam logic [7:0] PG           = misc_cfg_pkg::PAGE_SELECT_ADDR;

  logic                      clk, rst_n, clk_en, hang, src_en, addr_match, div_pulse;
  logic [6:0]                bus_addr, own_addr, r;
  logic [7:0]                rdata, d, v;
  misc_cfg_pkg::reg_access_t acc;
  misc_cfg_pkg::misc_ctrl_t  ctrl;
  int                        bad_count, compares, seed, n, i;

  misc_config_register_bank #(.PART_CODE(PART_CODE_TB)) uut (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_clk_en(clk_en), .i_access(acc),
    .o_rdata(rdata), .i_hang_detect(hang), .i_src_clk_en(src_en),
    .i_bus_addr(bus_addr), .i_own_addr(own_addr), .o_addr_match(addr_match),
    .o_div_pulse(div_pulse), .o_ctrl(ctrl));

  host_bus_model host (.i_core_clk(clk), .i_rdata(rdata), .o_access(acc));

  always #12.5 clk = ~clk;

  // ****************************************************************
  // Checking and expectations
  // ****************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (bad_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  function automatic logic [7:0] opt_exp(input logic seen, input logic gce);
    return {1'b0, ~seen, gce, 5'h00};
  endfunction

  function automatic int div_period(input logic [6:0] ratio);
    return (ratio == 7'h00) ? 128 : int'(ratio);
  endfunction

  task automatic next_pulse(output int cnt);
    cnt = 0;
    do begin
      @(negedge clk);
      cnt++;
    end while (div_pulse !== 1'b1 && cnt < 300);
    if (cnt >= 300) begin
      bad_count++;
      complete_run();
    end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    clk = 0; rst_n = 0; clk_en = 1; hang = 0; src_en = 1;
    bus_addr = '0; own_addr = 7'h11; seed = 48; bad_count = 0; compares = 0;
    repeat (16) @(negedge clk);
    rst_n = 1;
    host.rd(PG, d); check(d, 8'h01);
    host.rd(DIV, d); check(d, 8'h01);
    check({7'h00, ctrl.divider_power_on}, 8'h00);
    check({3'h0, ctrl.divider_clock_input}, 8'h0D);
    host.wr(misc_cfg_pkg::PART_ID_ADDR, ~PART_CODE_TB);
    host.rd(misc_cfg_pkg::PART_ID_ADDR, d); check(d, PART_CODE_TB);
    host.rd(8'h50, d); check(d, 8'h00);
    host.rd(OPT, d); check(d, opt_exp(1'b1, 1'b0));
    host.rd(OPT, d); check(d, opt_exp(1'b0, 1'b0));
    hang = 1;
    @(negedge clk); hang = 0;
    host.rd(OPT, d); check(d, opt_exp(1'b1, 1'b0));
    host.rd(OPT, d); check(d, opt_exp(1'b0, 1'b0));
    for (i = 0; i < 8; i++) begin
      own_addr = 7'($random(seed)) | 7'h01;
      host.wr(OPT, {2'b01, i[0], 5'h00});
      host.rd(OPT, d); check(d, opt_exp(1'b0, i[0]));
      bus_addr = i[1] ? own_addr : (i[2] ? 7'h00 : 7'($random(seed)));
      @(negedge clk);
      check({7'h00, addr_match}, {7'h00, bus_addr == own_addr || (i[0] && bus_addr == 7'h00)});
      check({7'h00, ctrl.general_call_enable}, {7'h00, i[0]});
    end
    for (i = 0; i < 5; i++) begin
      r = (i == 4) ? 7'($random(seed)) : ((i == 3) ? 7'h7F : 7'(i));
      host.wr(DIV, {1'b1, r});
      check({7'h00, ctrl.divider_power_on}, 8'h01);
      next_pulse(n);
      next_pulse(n);
      next_pulse(n);
      check(8'(n), 8'(div_period(r)));
    end
    host.wr(DIV, 8'h02);
    repeat (2) @(negedge clk);
    n = 0;
    repeat (300) begin
      @(negedge clk);
      n += (div_pulse === 1'b1) ? 1 : 0;
    end
    check(8'(n), 8'h00);
    v = 8'($random(seed));
    host.wr(MUX, v);
    host.rd(MUX, d); check(d, v & misc_cfg_pkg::CLKOUT_MUX_MASK);
    check({3'h0, ctrl.divider_clock_input}, {3'h0, v[4:0]});
    clk_en = 0;
    host.wr(MUX, ~v);
    clk_en = 1;
    host.rd(MUX, d); check(d, v & misc_cfg_pkg::CLKOUT_MUX_MASK);
    host.wr(PG, misc_cfg_pkg::RAMP_PAGE);
    host.rd(misc_cfg_pkg::PROTECTION_ADDR, d); check(d, 8'h03);
    host.rmw(misc_cfg_pkg::PROTECTION_ADDR, 8'h04, 8'h04);
    host.rd(misc_cfg_pkg::PROTECTION_ADDR, d); check(d, 8'h07);
    check({7'h00, ctrl.overtemp_retry_disable}, 8'h01);
    for (i = 0; i < 4; i++) begin
      v = (8'($random(seed)) & 8'hCC) | {2'b00, i[1:0], 2'b00, ~i[1:0]};
      host.wr(misc_cfg_pkg::RAMP_CTRL_ADDR, v);
      host.rd(misc_cfg_pkg::RAMP_CTRL_ADDR, d); check(d, v);
      check({6'h00, ctrl.ramp_freq}, {6'h00, v[5:4]});
      check({6'h00, ctrl.ramp_spread_depth}, {6'h00, v[1:0]});
    end
    host.wr(PG, 8'h03);
    host.wr(misc_cfg_pkg::RAMP_CTRL_ADDR, ~v);
    host.rd(misc_cfg_pkg::RAMP_CTRL_ADDR, d); check(d, 8'h00);
    host.rd(PG, d); check(d, 8'h03);
    host.wr(PG, misc_cfg_pkg::RAMP_PAGE);
    host.rd(misc_cfg_pkg::RAMP_CTRL_ADDR, d); check(d, v);
    rst_n = 0;
    @(negedge clk);
    rst_n = 1;
    host.rd(PG, d); check(d, 8'h01);
    complete_run();
  end
endmodule
